// [shared/vts_pkg.sv]
// Package of constants, types and register map for the transformer supervision block.
package vts_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int ARM_TIME_MS = 200;
  localparam int ARM_CYCLES = ARM_TIME_MS * CYC_PER_MS;
  localparam int OPER_TIME_MS = 4;
  localparam int OPER_CYCLES = OPER_TIME_MS * CYC_PER_MS;
  localparam int RELEASE_TIME_MS = 200;
  localparam int RELEASE_CYCLES = RELEASE_TIME_MS * CYC_PER_MS;
  localparam int LATCH_TIME_MS = 100;
  localparam int LATCH_CYCLES = LATCH_TIME_MS * CYC_PER_MS;
  localparam int CNT_W = 24;

  // ==========================================================================
  // Magnitude scaling: a magnitude equal to NOM_MAG is 100 percent of nominal.
  localparam int MAG_W = 16;
  localparam int THR_W = 7;
  localparam logic [23:0] NOM_MAG = 24'h001000;
  localparam logic [23:0] PCT_FULL = 24'h000064;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DL_VTHR = 8'h04;
  localparam logic [7:0] OFS_DL_ITHR = 8'h08;
  localparam logic [7:0] OFS_RES_VTHR = 8'h0c;
  localparam logic [7:0] OFS_RES_ITHR = 8'h10;
  localparam logic [7:0] OFS_NEG_VTHR = 8'h14;
  localparam logic [7:0] OFS_NEG_ITHR = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // Control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;

  // ==========================================================================
  // Threshold ranges and values after reset, in percent; enable bit value after reset
  localparam logic [6:0] DL_VTHR_MIN = 7'h0a;
  localparam logic [6:0] DL_VTHR_MAX = 7'h64;
  localparam logic [6:0] DL_VTHR_RST = 7'h3c;
  localparam logic [6:0] DL_ITHR_MIN = 7'h02;
  localparam logic [6:0] DL_ITHR_MAX = 7'h64;
  localparam logic [6:0] DL_ITHR_RST = 7'h0a;
  localparam logic [6:0] SEQ_VTHR_MIN = 7'h05;
  localparam logic [6:0] SEQ_VTHR_MAX = 7'h32;
  localparam logic [6:0] RES_VTHR_RST = 7'h1e;
  localparam logic [6:0] NEG_VTHR_RST = 7'h0a;
  localparam logic [6:0] SEQ_ITHR_MIN = 7'h0a;
  localparam logic [6:0] SEQ_ITHR_MAX = 7'h32;
  localparam logic [6:0] SEQ_ITHR_RST = 7'h0a;
  localparam logic CTRL_EN_RST = 1'b1;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    VTS_MODE_OFF = 2'h0,
    VTS_MODE_ZERO = 2'h1,
    VTS_MODE_NEG = 2'h2,
    VTS_MODE_SPECIAL = 2'h3
  } vts_mode_e;

  typedef enum logic [1:0] {
    VTS_SUP_DISARMED = 2'h0,
    VTS_SUP_ARMED = 2'h1,
    VTS_SUP_FAILED = 2'h3,
    VTS_SUP_LATCHED = 2'h2
  } vts_sup_e;

  typedef struct packed {
    logic [MAG_W-1:0] phase1_voltage_mag;
    logic [MAG_W-1:0] phase2_voltage_mag;
    logic [MAG_W-1:0] phase3_voltage_mag;
    logic [MAG_W-1:0] phase1_current_mag;
    logic [MAG_W-1:0] phase2_current_mag;
    logic [MAG_W-1:0] phase3_current_mag;
    logic [MAG_W-1:0] residual_voltage_mag;
    logic [MAG_W-1:0] residual_current_mag;
    logic [MAG_W-1:0] negseq_voltage_mag;
    logic [MAG_W-1:0] negseq_current_mag;
  } vts_mag_s;

  localparam vts_mode_e MODE_RST = VTS_MODE_ZERO;

endpackage

// [core/vts_supervision.sv]
// Dead-line detector and transformer supervision core with an APB register slave.
module vts_supervision #(
  parameter int ARM_CNT = vts_pkg::ARM_CYCLES,
  parameter int OPER_CNT = vts_pkg::OPER_CYCLES,
  parameter int RELEASE_CNT = vts_pkg::RELEASE_CYCLES,
  parameter int LATCH_CNT = vts_pkg::LATCH_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurements from the upstream calculations
  input wire vts_pkg::vts_mag_s mag,
  input wire logic mag_valid,
  input wire logic dead_line_block_in,
  // Detector flags
  output logic phase1_voltage_start,
  output logic phase2_voltage_start,
  output logic phase3_voltage_start,
  output logic phase1_current_start,
  output logic phase2_current_start,
  output logic phase3_current_start,
  output logic dead_line_flag,
  output logic line_healthy_flag,
  // To the downstream decision logic only
  output logic transformer_fail_internal
);
  import vts_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [THR_W-1:0] dl_vthr;
    logic [THR_W-1:0] dl_ithr;
    logic [THR_W-1:0] res_vthr;
    logic [THR_W-1:0] res_ithr;
    logic [THR_W-1:0] neg_vthr;
    logic [THR_W-1:0] neg_ithr;
    logic dld_en;
    vts_mode_e mode;
    logic [2:0] vstart;
    logic [2:0] istart;
    logic dead;
    logic healthy;
    logic cond;
    vts_sup_e sup;
    logic [CNT_W-1:0] hl_cnt;
    logic [CNT_W-1:0] cond_cnt;
    logic [CNT_W-1:0] rel_cnt;
    logic [CNT_W-1:0] age_cnt;
    logic rdy;
    logic slverr;
    logic [31:0] rdata;
  } vts_state_s;

  localparam logic [CNT_W-1:0] ARM_LAST = CNT_W'(ARM_CNT - 1);
  localparam logic [CNT_W-1:0] OPER_LAST = CNT_W'(OPER_CNT - 1);
  localparam logic [CNT_W-1:0] REL_LAST = CNT_W'(RELEASE_CNT - 1);
  localparam logic [CNT_W-1:0] AGE_FULL = CNT_W'(LATCH_CNT);

  vts_state_s state_r;
  vts_state_s state_nxt;

  // Magnitude times 100 against threshold times nominal keeps both sides integer.
  function automatic logic above(input logic [MAG_W-1:0] m, input logic [THR_W-1:0] t);
    above = ({8'h00, m} * PCT_FULL) > ({17'h00000, t} * NOM_MAG);
  endfunction

  function automatic logic below(input logic [MAG_W-1:0] m, input logic [THR_W-1:0] t);
    below = ({8'h00, m} * PCT_FULL) < ({17'h00000, t} * NOM_MAG);
  endfunction

  function automatic logic in_range(input logic [31:0] d, input logic [6:0] lo,
                                    input logic [6:0] hi);
    in_range = (d[31:7] == 25'h0000000) && (d[6:0] >= lo) && (d[6:0] <= hi);
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic run;
    logic [2:0] vab;
    logic [2:0] vbe;
    logic [2:0] iab;
    logic [2:0] ibe;
    logic wr;
    logic [THR_W-1:0] wv;
    logic ok;
    state_nxt = state_r;
    run = state_r.dld_en && !dead_line_block_in;
    vab = 3'h0;
    vbe = 3'h0;
    iab = 3'h0;
    ibe = 3'h0;
    wr = 1'b0;
    wv = pwdata[THR_W-1:0];
    ok = 1'b1;

    // Detector and condition, evaluated on each fresh sample.
    vab[0] = above(mag.phase1_voltage_mag, state_r.dl_vthr);
    vab[1] = above(mag.phase2_voltage_mag, state_r.dl_vthr);
    vab[2] = above(mag.phase3_voltage_mag, state_r.dl_vthr);
    vbe[0] = below(mag.phase1_voltage_mag, state_r.dl_vthr);
    vbe[1] = below(mag.phase2_voltage_mag, state_r.dl_vthr);
    vbe[2] = below(mag.phase3_voltage_mag, state_r.dl_vthr);
    iab[0] = above(mag.phase1_current_mag, state_r.dl_ithr);
    iab[1] = above(mag.phase2_current_mag, state_r.dl_ithr);
    iab[2] = above(mag.phase3_current_mag, state_r.dl_ithr);
    ibe[0] = below(mag.phase1_current_mag, state_r.dl_ithr);
    ibe[1] = below(mag.phase2_current_mag, state_r.dl_ithr);
    ibe[2] = below(mag.phase3_current_mag, state_r.dl_ithr);
    if (!run) begin
      state_nxt.vstart = 3'h0;
      state_nxt.istart = 3'h0;
      state_nxt.dead = 1'b0;
      state_nxt.healthy = 1'b0;
      state_nxt.cond = 1'b0;
    end else if (mag_valid) begin
      state_nxt.vstart = vab;
      state_nxt.istart = iab;
      state_nxt.dead = (&vbe) && (&ibe);
      state_nxt.healthy = &vab;
      unique case (state_r.mode)
        VTS_MODE_OFF: state_nxt.cond = 1'b0;
        VTS_MODE_ZERO: state_nxt.cond = above(mag.residual_voltage_mag, state_r.res_vthr)
                                        && below(mag.residual_current_mag, state_r.res_ithr);
        VTS_MODE_NEG: state_nxt.cond = above(mag.negseq_voltage_mag, state_r.neg_vthr)
                                       && below(mag.negseq_current_mag, state_r.neg_ithr);
        VTS_MODE_SPECIAL: state_nxt.cond = above(mag.residual_voltage_mag, state_r.res_vthr)
                                           && below(mag.residual_current_mag, state_r.res_ithr)
                                           && below(mag.negseq_current_mag, state_r.neg_ithr);
      endcase
    end

    // Healthy-hold timer for arming.
    if (state_r.healthy) begin
      if (state_r.hl_cnt != ARM_LAST) begin
        state_nxt.hl_cnt = state_r.hl_cnt + 1'b1;
      end
    end else begin
      state_nxt.hl_cnt = '0;
    end

    // Supervision sequence.
    state_nxt.cond_cnt = '0;
    state_nxt.rel_cnt = '0;
    unique case (state_r.sup)
      VTS_SUP_DISARMED: begin
        state_nxt.age_cnt = '0;
        if (run && state_r.healthy && state_r.hl_cnt == ARM_LAST) begin
          state_nxt.sup = VTS_SUP_ARMED;
        end
      end
      VTS_SUP_ARMED: begin
        state_nxt.age_cnt = '0;
        if (!run || state_r.dead) begin
          state_nxt.sup = VTS_SUP_DISARMED;
        end else if (state_r.cond) begin
          state_nxt.cond_cnt = state_r.cond_cnt + 1'b1;
          if (state_r.cond_cnt == OPER_LAST) begin
            state_nxt.sup = VTS_SUP_FAILED;
            state_nxt.cond_cnt = '0;
          end
        end
      end
      VTS_SUP_FAILED, VTS_SUP_LATCHED: begin
        if (state_r.age_cnt != AGE_FULL) begin
          state_nxt.age_cnt = state_r.age_cnt + 1'b1;
        end
        if (!run) begin
          state_nxt.sup = VTS_SUP_DISARMED;
        end else if (state_r.dead && state_r.sup == VTS_SUP_FAILED) begin
          // A short failure at de-energising is treated as a transient.
          state_nxt.sup = (state_r.age_cnt == AGE_FULL) ? VTS_SUP_LATCHED
                                                        : VTS_SUP_DISARMED;
        end else if (state_r.healthy && !state_r.cond) begin
          state_nxt.rel_cnt = state_r.rel_cnt + 1'b1;
          if (state_r.rel_cnt == REL_LAST) begin
            state_nxt.sup = VTS_SUP_ARMED;
            state_nxt.rel_cnt = '0;
          end
        end
      end
    endcase

    // APB: one wait state; reads and errors are prepared before pready rises.
    state_nxt.rdy = 1'b0;
    if (psel && penable && !state_r.rdy) begin
      state_nxt.rdy = 1'b1;
      state_nxt.rdata = 32'h00000000;
      unique case (paddr)
        OFS_CTRL: state_nxt.rdata = {29'h00000000, state_r.mode, state_r.dld_en};
        OFS_DL_VTHR: state_nxt.rdata = {25'h0000000, state_r.dl_vthr};
        OFS_DL_ITHR: state_nxt.rdata = {25'h0000000, state_r.dl_ithr};
        OFS_RES_VTHR: state_nxt.rdata = {25'h0000000, state_r.res_vthr};
        OFS_RES_ITHR: state_nxt.rdata = {25'h0000000, state_r.res_ithr};
        OFS_NEG_VTHR: state_nxt.rdata = {25'h0000000, state_r.neg_vthr};
        OFS_NEG_ITHR: state_nxt.rdata = {25'h0000000, state_r.neg_ithr};
        OFS_STATUS: state_nxt.rdata = {23'h000000, state_r.sup != VTS_SUP_DISARMED,
                                       state_r.healthy, state_r.dead,
                                       state_r.istart, state_r.vstart};
        default: ok = 1'b0;
      endcase
      if (pwrite) begin
        unique case (paddr)
          OFS_CTRL: ok = (pwdata[31:3] == 29'h00000000);
          OFS_DL_VTHR: ok = in_range(pwdata, DL_VTHR_MIN, DL_VTHR_MAX);
          OFS_DL_ITHR: ok = in_range(pwdata, DL_ITHR_MIN, DL_ITHR_MAX);
          OFS_RES_VTHR, OFS_NEG_VTHR: ok = in_range(pwdata, SEQ_VTHR_MIN, SEQ_VTHR_MAX);
          OFS_RES_ITHR, OFS_NEG_ITHR: ok = in_range(pwdata, SEQ_ITHR_MIN, SEQ_ITHR_MAX);
          default: ok = 1'b0;
        endcase
      end
      state_nxt.slverr = !ok;
    end

    // A refused write leaves the register unchanged.
    wr = psel && penable && state_r.rdy && pwrite && !state_r.slverr;
    if (wr) begin
      unique case (paddr)
        OFS_CTRL: begin
          state_nxt.dld_en = pwdata[CTRL_EN_BIT];
          state_nxt.mode = vts_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
        end
        OFS_DL_VTHR: state_nxt.dl_vthr = wv;
        OFS_DL_ITHR: state_nxt.dl_ithr = wv;
        OFS_RES_VTHR: state_nxt.res_vthr = wv;
        OFS_RES_ITHR: state_nxt.res_ithr = wv;
        OFS_NEG_VTHR: state_nxt.neg_vthr = wv;
        OFS_NEG_ITHR: state_nxt.neg_ithr = wv;
        default: state_nxt.dld_en = state_r.dld_en;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= '0;
      state_r.dl_vthr <= DL_VTHR_RST;
      state_r.dl_ithr <= DL_ITHR_RST;
      state_r.res_vthr <= RES_VTHR_RST;
      state_r.res_ithr <= SEQ_ITHR_RST;
      state_r.neg_vthr <= NEG_VTHR_RST;
      state_r.neg_ithr <= SEQ_ITHR_RST;
      state_r.dld_en <= CTRL_EN_RST;
      state_r.mode <= MODE_RST;
      state_r.sup <= VTS_SUP_DISARMED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata = state_r.rdata;
  assign pready = state_r.rdy;
  assign pslverr = state_r.rdy && state_r.slverr;
  assign phase1_voltage_start = state_r.vstart[0];
  assign phase2_voltage_start = state_r.vstart[1];
  assign phase3_voltage_start = state_r.vstart[2];
  assign phase1_current_start = state_r.istart[0];
  assign phase2_current_start = state_r.istart[1];
  assign phase3_current_start = state_r.istart[2];
  assign dead_line_flag = state_r.dead;
  assign line_healthy_flag = state_r.healthy;
  assign transformer_fail_internal = state_r.sup[1];

endmodule

// [sim/vts_supervision_asserts.sv]
// Port checker for the transformer supervision block, bound onto its top module.
module vts_supervision_asserts #(
  parameter int ARM_CNT = vts_pkg::ARM_CYCLES,
  parameter int LATCH_CNT = vts_pkg::LATCH_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Detector and supervision
  input wire logic dead_line_block_in,
  input wire logic phase1_voltage_start,
  input wire logic phase2_voltage_start,
  input wire logic phase3_voltage_start,
  input wire logic phase1_current_start,
  input wire logic phase2_current_start,
  input wire logic phase3_current_start,
  input wire logic dead_line_flag,
  input wire logic line_healthy_flag,
  input wire logic transformer_fail_internal
);
  import vts_pkg::*;
  // ==========================================================================
  // Helper counters
  logic [5:0] starts;
  int unsigned hcnt_r;
  int unsigned fcnt_r;
  logic armed_r;
  assign starts = {phase3_current_start, phase2_current_start, phase1_current_start,
                   phase3_voltage_start, phase2_voltage_start, phase1_voltage_start};
  // The arm tracker only sees flags, so a disable by the enable bit leaves it set: weaker, never false.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hcnt_r <= 0;
      fcnt_r <= 0;
      armed_r <= 1'b0;
    end else begin
      hcnt_r <= line_healthy_flag ? hcnt_r + 1 : 0;
      fcnt_r <= transformer_fail_internal ? fcnt_r + 1 : 0;
      armed_r <= !(dead_line_flag || dead_line_block_in) && (armed_r || hcnt_r >= ARM_CNT);
    end
  end
  // ==========================================================================
  // Assertions
  default clocking dflt @(posedge clk);
  endclocking
  default disable iff (reset);
  healthy_starts_a: assert property (line_healthy_flag |-> starts[2:0] == 3'h7)
    else $error("healthy flag without all voltage starts");
  dead_quiet_a: assert property (dead_line_flag |-> starts == 6'h0)
    else $error("dead flag with a start flag set");
  block_flags_a: assert property (dead_line_block_in [*2] |->
    starts == 6'h0 && !dead_line_flag && !line_healthy_flag)
    else $error("detector flags while blocked");
  block_fail_a: assert property (dead_line_block_in [*2] |-> !transformer_fail_internal)
    else $error("failure flag while blocked");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer not after one wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  fail_armed_a: assert property ($rose(transformer_fail_internal) |-> armed_r)
    else $error("failure rose without arming");
  short_dead_a: assert property ($rose(dead_line_flag) && transformer_fail_internal &&
    fcnt_r < LATCH_CNT - 2 |-> ##[1:2] !transformer_fail_internal)
    else $error("young failure kept on dead line");
  latch_hold_a: assert property ($rose(dead_line_flag) && fcnt_r > LATCH_CNT + 2 |->
    ##1 transformer_fail_internal [*4])
    else $error("old failure dropped on dead line");
  fail_seen_c: cover property ($rose(transformer_fail_internal));
  latch_seen_c: cover property ($rose(dead_line_flag) && transformer_fail_internal);
  refuse_seen_c: cover property (pslverr);
endmodule

bind vts_supervision vts_supervision_asserts #(.ARM_CNT(ARM_CNT), .LATCH_CNT(LATCH_CNT)) u_chk (
  .clk, .reset, .psel, .penable, .pready, .pslverr, .dead_line_block_in,
  .phase1_voltage_start, .phase2_voltage_start, .phase3_voltage_start,
  .phase1_current_start, .phase2_current_start, .phase3_current_start,
  .dead_line_flag, .line_healthy_flag, .transformer_fail_internal
);

// [sim/vts_meas_model.sv]
// Model of the upstream magnitude calculations feeding the supervision block.
module vts_meas_model #(
  parameter int PERIOD = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sample chosen by the bench
  input wire vts_pkg::vts_mag_s sample,
  // Toward the block
  output vts_pkg::vts_mag_s mag,
  output logic mag_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import vts_pkg::*;
  int unsigned cnt_r;
  // Between strobes the bus carries the inverse, so a block that reads it unqualified fails.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 0;
      mag_valid <= 1'b0;
      mag <= '0;
    end else begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      mag_valid <= (cnt_r == 0);
      mag <= (cnt_r == 0) ? sample : ~sample;
    end
  end
endmodule

// [sim/test_vts_supervision.sv]
// Self-checking bench for the transformer supervision block.
module test_vts_supervision;
  timeunit 1ns;
  timeprecision 1ps;
  import vts_pkg::*;
  localparam int ARM = 20;
  localparam int OPER = 4;
  localparam int REL = 20;
  localparam int LATCH = 40;
  localparam logic [15:0] HI = 16'h1000;
  localparam logic [15:0] LO = 16'h0100;
  localparam logic [95:0] PH_OK = {HI, HI, HI, LO, LO, LO};
  localparam logic [95:0] PH_DEAD = {LO, LO, LO, LO, LO, LO};
  localparam logic [63:0] S_NONE = {LO, LO, LO, LO};
  localparam logic [63:0] SEQ_TAB [3] = '{{HI, LO, LO, HI}, {LO, LO, HI, LO}, {HI, LO, LO, LO}};
  localparam logic [3:0] MODE_TAB [3] = '{4'b0010, 4'b0100, 4'b1010};
  localparam logic [31:0] RST_TAB [7] = '{32'h3, 32'h3c, 32'h0a, 32'h1e, 32'h0a, 32'h0a, 32'h0a};
  localparam logic [31:0] BAD_TAB [7] = '{32'h9, 32'h65, 32'h33, 32'h9, 32'h4, 32'h33, 32'h0};
  // ==========================================================================
  // Signals
  logic clk, reset, psel, penable, pwrite, mag_valid, dead_line_block_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, dead_line_flag, line_healthy_flag, transformer_fail_internal;
  logic phase1_voltage_start, phase2_voltage_start, phase3_voltage_start;
  logic phase1_current_start, phase2_current_start, phase3_current_start;
  logic [7:0] flags;
  vts_mag_s smp, mag;
  int err_count = 0;
  int comparisons = 0;
  assign flags = {line_healthy_flag, dead_line_flag, phase3_current_start, phase2_current_start,
                  phase1_current_start, phase3_voltage_start, phase2_voltage_start,
                  phase1_voltage_start};
  vts_supervision #(.ARM_CNT(ARM), .OPER_CNT(OPER), .RELEASE_CNT(REL), .LATCH_CNT(LATCH))
    i_vts_supervision (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mag, .mag_valid, .dead_line_block_in, .phase1_voltage_start,
    .phase2_voltage_start, .phase3_voltage_start, .phase1_current_start, .phase2_current_start,
    .phase3_current_start, .dead_line_flag, .line_healthy_flag, .transformer_fail_internal);
  vts_meas_model i_vts_meas_model (.clk, .reset, .sample(smp), .mag, .mag_valid);
  // ==========================================================================
  // Tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic ge;
    apb(1'b1, a, d, r, ge);
    chk_bit(ge, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
    logic [31:0] r;
    logic ge;
    apb(1'b0, a, 32'h0, r, ge);
    chk_bit(ge, e);
    if (!e) chk_word(r, exp);
  endtask
  task automatic put(input logic [95:0] ph, input logic [63:0] seq, input int n);
    smp <= {ph, seq};
    repeat (n) @(posedge clk);
  endtask
  task automatic det(input logic [95:0] ph, input logic [7:0] exp);
    put(ph, S_NONE, 8);
    chk_word({24'h0, flags}, {24'h0, exp});
  endtask
  task automatic arm_run(input logic [1:0] m, input logic [63:0] seq);
    wr(OFS_CTRL, {29'h0, m, 1'b1}, 1'b0);
    put(PH_DEAD, S_NONE, 8);
    put(PH_OK, seq, ARM - 4);
    chk_bit(transformer_fail_internal, 1'b0);
    repeat (OPER + 20) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock, watchdog and test sequence
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, dead_line_block_in} = {1'b1, 44'h0};
    smp = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 7; k++) rd(8'(4 * k), RST_TAB[k], 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    for (int k = 0; k < 7; k++) wr(8'(4 * k + 4), BAD_TAB[k], 1'b1);
    for (int k = 0; k < 7; k++) rd(8'(4 * k), RST_TAB[k], 1'b0);
    $display("test registers done");
    det(PH_OK, 8'h87);
    det(PH_DEAD, 8'h40);
    rd(OFS_STATUS, 32'h40, 1'b0);
    det({HI, LO, HI, LO, LO, HI}, 8'h25);
    det({LO, LO, LO, HI, LO, LO}, 8'h08);
    wr(OFS_DL_VTHR, 32'h64, 1'b0);
    det(PH_OK, 8'h00);
    wr(OFS_DL_VTHR, 32'h3c, 1'b0);
    dead_line_block_in <= 1'b1;
    det(PH_OK, 8'h00);
    dead_line_block_in <= 1'b0;
    $display("test detector done");
    for (int s = 0; s < 3; s++) begin
      for (int m = 0; m < 4; m++) begin
        arm_run(2'(m), SEQ_TAB[s]);
        chk_bit(transformer_fail_internal, MODE_TAB[s][m]);
        if (MODE_TAB[s][m]) begin
          put(PH_OK, S_NONE, REL - 6);
          chk_bit(transformer_fail_internal, 1'b1);
          put(PH_OK, S_NONE, 20);
          chk_bit(transformer_fail_internal, 1'b0);
        end
      end
    end
    $display("test modes done");
    arm_run(2'h1, SEQ_TAB[0]);
    put(PH_DEAD, S_NONE, 8);
    chk_bit(transformer_fail_internal, 1'b0);
    arm_run(2'h1, SEQ_TAB[0]);
    put(PH_OK, SEQ_TAB[0], LATCH);
    put(PH_DEAD, S_NONE, 8);
    chk_bit(transformer_fail_internal, 1'b1);
    put(PH_OK, S_NONE, REL + 20);
    chk_bit(transformer_fail_internal, 1'b0);
    $display("test latch done");
    arm_run(2'h1, SEQ_TAB[0]);
    chk_bit(transformer_fail_internal, 1'b1);
    wr(OFS_CTRL, 32'h2, 1'b0);
    repeat (2) @(posedge clk);
    chk_bit(transformer_fail_internal, 1'b0);
    chk_word({24'h0, flags}, 32'h0);
    arm_run(2'h1, SEQ_TAB[0]);
    dead_line_block_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit(transformer_fail_internal, 1'b0);
    dead_line_block_in <= 1'b0;
    $display("test disable done");
    finish_test();
  end
endmodule
